// File: swc_pkg.sv
// swc_pkg: constants and types shared by the sleep and wake-up controller
// assumes a 40 MHz core clock and an 8-bit register port
package swc_pkg;
  // register port geometry
  localparam int          SWC_ADDR_W      = 4;
  localparam int          SWC_DATA_W      = 8;
  // register indices (offsets not printed, chosen locally)
  localparam logic [3:0]  SWC_REG_REGCTL  = 4'h0;
  localparam logic [3:0]  SWC_REG_STATUS  = 4'h1;
  localparam logic [3:0]  SWC_REG_INTCTL  = 4'h2;
  localparam logic [3:0]  SWC_REG_SLEEP   = 4'h3;
  // regulator control fields
  localparam int          SWC_RC_RSVD_BIT = 0;
  localparam int          SWC_RC_PM_BIT   = 1;
  localparam logic [7:0]  SWC_RC_RESET    = 8'h01;
  localparam logic [7:0]  SWC_RC_MASK     = 8'h03;
  // status fields
  localparam int          SWC_ST_PD_BIT   = 0;
  localparam int          SWC_ST_TO_BIT   = 1;
  localparam int          SWC_ST_SLP_BIT  = 2;
  localparam int          SWC_ST_OST_BIT  = 3;
  // interrupt control fields
  localparam int          SWC_IC_GIE_BIT  = 0;
  // sleep command value
  localparam logic [7:0]  SWC_SLEEP_CMD   = 8'h01;
  // interrupt source count
  localparam int          SWC_NSRC        = 8;
  // oscillator start-up delay in oscillator periods
  localparam int          SWC_OST_PERIODS = 1024;
  localparam int          SWC_OST_W       = 11;
  localparam logic [10:0] SWC_OST_LAST    = 11'(SWC_OST_PERIODS - 1);
  // forced no-op cycles before the vector fetch
  localparam logic [1:0]  SWC_FNOP_CYCLES = 2'h2;
  // oscillator modes
  typedef enum logic [1:0] {
    SWC_OSC_CRYSTAL = 2'h0,
    SWC_OSC_EXTCLK  = 2'h1,
    SWC_OSC_RC      = 2'h2,
    SWC_OSC_INTERNAL_OSCILLATOR_MODE  = 2'h3
  } swc_osc_t;
  // controller states, one-hot
  typedef enum logic [4:0] {
    SWC_RUN   = 5'b0_0001,
    SWC_SLEEP = 5'b0_0010,
    SWC_OST   = 5'b0_0100,
    SWC_NEXT  = 5'b0_1000,
    SWC_FNOP  = 5'b1_0000
  } swc_state_t;
endpackage

// File: swc_ost_counter.sv
// swc_ost_counter: counts oscillator periods for the start-up delay
// assumes osc_tick_i is a one-cycle pulse per oscillator period, on clock_i
`timescale 1ns/1ps
module swc_ost_counter import swc_pkg::*; (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // control
  input  wire logic start_i,
  input  wire logic osc_tick_i,
  // status
  output logic      done_o
);
  logic [SWC_OST_W-1:0] cnt_q, cnt_d;   // periods counted
  logic                 run_q, run_d;   // counting
  logic                 done_q, done_d; // one-cycle finish pulse

  // next-state of the counter
  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (start_i) begin
      // restart from zero
      cnt_d = '0;
      run_d = 1'b1;
    end else if (run_q && osc_tick_i) begin
      if (cnt_q == SWC_OST_LAST) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
endmodule // swc_ost_counter

// File: swc_sleep_ctrl.sv
// swc_sleep_ctrl: sleep entry, wake-up on enabled interrupts, regulator mode
// assumes core, interrupt sources and watchdog sit on clock_i
// assumes the watchdog restarts itself on watchdog_timer_clear_o
// assumes software sends the sleep command only while the core runs
`timescale 1ns/1ps
module swc_sleep_ctrl import swc_pkg::*; (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  // register port
  input  wire logic [SWC_ADDR_W-1:0] addr_i,
  input  wire logic [SWC_DATA_W-1:0] wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [SWC_DATA_W-1:0] rdata_o,
  // interrupt sources
  input  wire logic [SWC_NSRC-1:0]   int_enable_i,
  input  wire logic [SWC_NSRC-1:0]   int_flag_i,
  // clock source
  input  wire swc_osc_t              osc_mode_i,
  input  wire logic                  two_speed_i,
  input  wire logic                  osc_tick_i,
  // core and power outputs
  output logic                       core_halt_o,
  output logic                       exec_next_o,
  output logic                       forced_nop_o,
  output logic                       vector_o,
  output logic                       watchdog_timer_clear_o,
  output logic                       low_power_sleep_o
);
  // register state
  logic [1:0]  regctl_q, regctl_d;              // power select and reserved bit
  logic        global_interrupt_enable_q, global_interrupt_enable_d;
  logic        timeout_status_flag_q, timeout_status_flag_d;
  logic        powerdown_status_flag_q, powerdown_status_flag_d;
  logic        wdt_clr_q, wdt_clr_d;            // watchdog clear pulse
  logic [7:0]  rdata_q, rdata_d;                // read data register
  swc_state_t  state_q, state_d;                // sequencer state
  logic [1:0]  fnop_q, fnop_d;                  // forced no-op counter
  logic        ost_start;                       // starts start-up delay
  logic        ost_done;                        // start-up delay finished
  logic        pending;                         // any enabled flag set
  logic        sleep_req;                       // sleep command written

  // a source wakes the core on enable and flag alone; the global
  // enable only decides whether the vector follows the wake
  // enable and flag, no global term
  assign pending   = |(int_enable_i & int_flag_i);
  // the sleep command is a write of the command value to its index
  assign sleep_req = wr_i && (addr_i == SWC_REG_SLEEP) && (wdata_i == SWC_SLEEP_CMD);

  // decode of a register index against the port address
  function automatic logic hit(input logic [SWC_ADDR_W-1:0] a, input logic [3:0] idx);
    hit = (a == idx);
  endfunction

  // start-up delay counter
  swc_ost_counter u_ost (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .start_i    (ost_start),
    .osc_tick_i (osc_tick_i),
    .done_o     (ost_done)
  );

  // sequencer and flags next state
  always_comb begin
    // defaults: hold state, no pulses
    state_d                 = state_q;
    fnop_d                  = fnop_q;
    timeout_status_flag_d   = timeout_status_flag_q;
    powerdown_status_flag_d = powerdown_status_flag_q;
    wdt_clr_d               = 1'b0;
    ost_start               = 1'b0;
    case (state_q)
      SWC_RUN: begin
        if (sleep_req) begin
          // pending in the command cycle decides; a source that turns
          // up one cycle later wakes the core from sleep instead
          // sleep runs as a no-op
          if (pending) begin
            state_d = SWC_RUN;
          end else begin
            // sleep executes: clear watchdog, set time-out, clear power-down
            state_d                 = SWC_SLEEP;
            wdt_clr_d               = 1'b1;
            timeout_status_flag_d   = 1'b1;
            powerdown_status_flag_d = 1'b0;
          end
        end
      end
      SWC_SLEEP: begin
        if (pending) begin
          if (osc_mode_i == SWC_OSC_CRYSTAL && !two_speed_i) begin
            ost_start = 1'b1;
            state_d   = SWC_OST;
          end else begin
            // fast clock modes run at once, no settling wait
            state_d = SWC_NEXT;
          end
        end
      end
      SWC_OST: begin
        // hold until the oscillator has settled
        if (ost_done) begin
          state_d = SWC_NEXT;
        end
      end
      SWC_NEXT: begin
        // one instruction, then vector or continue
        if (global_interrupt_enable_q) begin
          state_d = SWC_FNOP;
          fnop_d  = SWC_FNOP_CYCLES;
        end else begin
          state_d = SWC_RUN;
        end
      end
      SWC_FNOP: begin
        // counter loaded with the no-op count on entry, so the
        // vector pulse falls on the last no-op
        // forced no-ops before vector
        if (fnop_q == 2'h1) begin
          state_d = SWC_RUN;
        end
        fnop_d = fnop_q - 2'h1;
      end
      default: begin
        // an illegal state code falls back to running
        state_d = SWC_RUN;
      end
    endcase
  end

  // software register writes and read data
  always_comb begin
    regctl_d                  = regctl_q;
    global_interrupt_enable_d = global_interrupt_enable_q;
    // read data are zero outside the answer cycle
    rdata_d                   = 8'h00;
    if (wr_i && hit(addr_i, SWC_REG_REGCTL)) begin
      regctl_d[SWC_RC_PM_BIT]   = wdata_i[SWC_RC_PM_BIT];
      // the written value of the reserved bit is ignored, so a
      // careless write can never clear it
      // reserved bit held set
      regctl_d[SWC_RC_RSVD_BIT] = 1'b1;
    end
    if (wr_i && hit(addr_i, SWC_REG_INTCTL)) begin
      // global enable only steers what follows a wake
      global_interrupt_enable_d = wdata_i[SWC_IC_GIE_BIT];
    end
    if (rd_i) begin
      if (hit(addr_i, SWC_REG_REGCTL)) begin
        rdata_d = {6'h00, regctl_q} & SWC_RC_MASK;
      end else if (hit(addr_i, SWC_REG_STATUS)) begin
        rdata_d[SWC_ST_PD_BIT]  = powerdown_status_flag_q;
        rdata_d[SWC_ST_TO_BIT]  = timeout_status_flag_q;
        rdata_d[SWC_ST_SLP_BIT] = (state_q == SWC_SLEEP);
        rdata_d[SWC_ST_OST_BIT] = (state_q == SWC_OST);
      end else if (hit(addr_i, SWC_REG_INTCTL)) begin
        rdata_d[SWC_IC_GIE_BIT] = global_interrupt_enable_q;
      end else begin
        // unmapped reads zero
        rdata_d = 8'h00;
      end
    end
  end

  // sequencer registers: state, no-op counter, status flags, watchdog pulse
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q                   <= SWC_RUN;
      fnop_q                    <= 2'h0;
      timeout_status_flag_q     <= 1'b1;
      powerdown_status_flag_q   <= 1'b1;
      wdt_clr_q                 <= 1'b0;
    end else begin
      state_q                   <= state_d;
      fnop_q                    <= fnop_d;
      timeout_status_flag_q     <= timeout_status_flag_d;
      powerdown_status_flag_q   <= powerdown_status_flag_d;
      wdt_clr_q                 <= wdt_clr_d;
    end
  end

  // software registers and read data
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      regctl_q                  <= SWC_RC_RESET[1:0];
      global_interrupt_enable_q <= 1'b0;
      rdata_q                   <= 8'h00;
    end else begin
      regctl_q                  <= regctl_d;
      global_interrupt_enable_q <= global_interrupt_enable_d;
      rdata_q                   <= rdata_d;
    end
  end

  // outputs
  assign rdata_o                = rdata_q;
  // halt covers the start-up wait too, so the core stays stopped
  // until the oscillator has settled
  assign core_halt_o            = (state_q == SWC_SLEEP) || (state_q == SWC_OST);
  assign exec_next_o            = (state_q == SWC_NEXT);
  assign forced_nop_o           = (state_q == SWC_FNOP);
  assign vector_o               = (state_q == SWC_FNOP) && (fnop_q == 2'h1);
  assign watchdog_timer_clear_o = wdt_clr_q;
  assign low_power_sleep_o      = regctl_q[SWC_RC_PM_BIT] && core_halt_o;
endmodule // swc_sleep_ctrl

// File: swc_checker.sv
// swc_checker: port checks for the sleep and wake-up controller
// assumes it is bound to swc_sleep_ctrl on one clock
`timescale 1ns/1ps
module swc_checker import swc_pkg::*; (
  // clock and reset
  input wire logic                  clock_i,
  input wire logic                  rst_i,
  // register port
  input wire logic [SWC_ADDR_W-1:0] addr_i,
  input wire logic [SWC_DATA_W-1:0] wdata_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [SWC_DATA_W-1:0] rdata_o,
  // interrupt sources
  input wire logic [SWC_NSRC-1:0]   int_enable_i,
  input wire logic [SWC_NSRC-1:0]   int_flag_i,
  // clock source
  input wire swc_osc_t              osc_mode_i,
  input wire logic                  two_speed_i,
  input wire logic                  osc_tick_i,
  // core and power outputs
  input wire logic                  core_halt_o,
  input wire logic                  exec_next_o,
  input wire logic                  forced_nop_o,
  input wire logic                  vector_o,
  input wire logic                  watchdog_timer_clear_o,
  input wire logic                  low_power_sleep_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // pending source, sleep command and slow start-up decode
  wire logic pend = |(int_enable_i & int_flag_i);
  wire logic cmd  = wr_i && addr_i == SWC_REG_SLEEP && wdata_i == SWC_SLEEP_CMD;
  wire logic slow = osc_mode_i == SWC_OSC_CRYSTAL && !two_speed_i;
  logic pm_q, pm_d;  // shadow of the power-select bit
  always_comb pm_d = (wr_i && addr_i == SWC_REG_REGCTL) ? wdata_i[SWC_RC_PM_BIT] : pm_q;
  // shadow register, cleared like the power-select bit
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pm_q <= 1'b0;
    end else begin
      pm_q <= pm_d;
    end
  end
  chk_wake_any: assert property (core_halt_o && pend && !slow |=> exec_next_o)
    else $error("no wake on pending source");
  chk_nop_pend: assert property (cmd && pend && !core_halt_o |=> !watchdog_timer_clear_o && !core_halt_o)
    else $error("sleep not skipped");
  chk_sleep_go: assert property (cmd && !pend && !core_halt_o |=> watchdog_timer_clear_o && core_halt_o)
    else $error("sleep not entered");
  chk_lp_sel: assert property (low_power_sleep_o == (core_halt_o && pm_q))
    else $error("power select wrong");
  chk_rsvd_one: assert property (rd_i && addr_i == SWC_REG_REGCTL |=> rdata_o[SWC_RC_RSVD_BIT])
    else $error("reserved bit not one");
  chk_upper_zero: assert property (rd_i && addr_i == SWC_REG_REGCTL |=> rdata_o[7:2] == 6'h00)
    else $error("upper bits not zero");
  chk_ost_wait: assert property (core_halt_o && $rose(pend) && slow |=> core_halt_o [*8])
    else $error("start-up delay skipped");
  chk_nop_vec: assert property ($rose(forced_nop_o) |-> $past(exec_next_o) && !vector_o
    ##1 forced_nop_o && vector_o ##1 !forced_nop_o)
    else $error("forced no-op order wrong");
  cover property (exec_next_o && slow);
  cover property (vector_o);
  cover property (cmd && pend);
endmodule // swc_checker
bind swc_sleep_ctrl swc_checker u_chk (.*);

// File: swc_src_model.sv
// swc_src_model: interrupt sources and crystal oscillator
// assumes fire and clear requests arrive on clock_i
`timescale 1ns/1ps
module swc_src_model import swc_pkg::*; (
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // bench requests
  input  wire logic [SWC_NSRC-1:0] mask_i,
  input  wire logic [SWC_NSRC-1:0] fire_i,
  input  wire logic                clr_i,
  // toward the controller
  output logic      [SWC_NSRC-1:0] int_enable_o,
  output logic      [SWC_NSRC-1:0] int_flag_o,
  output logic                     osc_tick_o
);
  // flags latch until cleared; one oscillator period per two cycles
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      int_flag_o <= '0;
      osc_tick_o <= 1'b0;
    end else begin
      int_flag_o <= clr_i ? '0 : (int_flag_o | fire_i);
      osc_tick_o <= ~osc_tick_o;
    end
  end
  assign int_enable_o = mask_i;
endmodule // swc_src_model

// File: tb.sv
// tb: self-checking bench for the sleep and wake-up controller
// assumes controller, checker and source model compiled first
`timescale 1ns/1ps
module tb import swc_pkg::*;;
  logic                  clock_i, rst_i, wr_i, rd_i, two_speed_i, clr, osc_tick_i;
  logic [SWC_ADDR_W-1:0] addr_i;
  logic [SWC_DATA_W-1:0] wdata_i, rdata_o, to_pd;
  logic [SWC_NSRC-1:0]   int_enable_i, int_flag_i, mask, fire;
  logic                  core_halt_o, exec_next_o, forced_nop_o, vector_o;
  logic                  watchdog_timer_clear_o, low_power_sleep_o;
  swc_osc_t              osc_mode_i;
  logic [31:0]           rnd;
  int                    fails, total_checks, n;
  swc_sleep_ctrl u_dut (.*);
  swc_src_model u_src (.clock_i(clock_i), .rst_i(rst_i), .mask_i(mask), .fire_i(fire), .clr_i(clr),
    .int_enable_o(int_enable_i), .int_flag_o(int_flag_i), .osc_tick_o(osc_tick_i));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk("rdata", e, rdata_o);
  endtask
  task automatic unflag();
    @(posedge clock_i);
    fire <= '0;
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
  endtask
  // enabled source already pending: command must do nothing
  task automatic noop();
    @(posedge clock_i);
    mask <= 8'h01;
    fire <= 8'h01;
    wr(SWC_REG_SLEEP, SWC_SLEEP_CMD);
    #1 chk("wdt", 8'h00, watchdog_timer_clear_o);
    chk("halt", 8'h00, core_halt_o);
    rd(SWC_REG_STATUS, to_pd);
    unflag();
  endtask
  // sleep, then wake through one enabled source
  task automatic nap(input logic [1:0] m, input logic t, p, g);
    logic [7:0] b;
    b = 8'h01 << rnd[2:0];
    @(posedge clock_i);
    osc_mode_i <= swc_osc_t'(m);
    two_speed_i <= t;
    mask <= b;
    fire <= ~b;
    wr(SWC_REG_REGCTL, {6'h00, p, 1'b1});
    wr(SWC_REG_INTCTL, {7'h00, g});
    wr(SWC_REG_SLEEP, SWC_SLEEP_CMD);
    #1 chk("wdt", 8'h01, watchdog_timer_clear_o);
    chk("lp", {7'h00, p}, low_power_sleep_o);
    to_pd = 8'h02;
    rd(SWC_REG_STATUS, 8'h06);
    rd(SWC_REG_REGCTL, {6'h00, p, 1'b1});
    @(posedge clock_i);
    fire <= b;
    n = 0;
    while (exec_next_o !== 1'b1 && n < 2200) begin
      @(posedge clock_i);
      #1 n++;
    end
    if (n == 2200) begin
      fails++;
      complete_run();
    end
    chk("wait", (m == 2'h0 && !t) ? 8'h02 : 8'h01, {6'h00, n >= 2 * SWC_OST_PERIODS, n <= 2});
    @(posedge clock_i);
    #1 chk("nop", {7'h00, g}, forced_nop_o);
    @(posedge clock_i);
    #1 chk("vec", {7'h00, g}, vector_o);
    unflag();
    rd(SWC_REG_STATUS, to_pd);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    // hold reset, all strobes and requests idle
    rst_i = 1'b1;
    {wr_i, rd_i, two_speed_i, clr} = 4'h0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    mask = 8'h00;
    fire = 8'h00;
    osc_mode_i = SWC_OSC_CRYSTAL;
    fails = 0;
    total_checks = 0;
    rnd = 32'h150f;
    to_pd = 8'h03;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(SWC_REG_REGCTL, SWC_RC_RESET);
    rd(SWC_REG_STATUS, to_pd);
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h00);
    noop();
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(SWC_REG_REGCTL, rnd[7:0] | 8'h01);
      rd(SWC_REG_REGCTL, {6'h00, rnd[1], 1'b1});
    end
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      nap(i[1:0], i > 3, rnd[3], i[0]);
    end
    noop();
    complete_run();
  end
endmodule // tb
